// >>> logic/clock_switcher.sv
// Clock switch sequencer: walks the current source over to the requested one.
module clock_switcher
	import osc_ctrl_pkg::*;
(
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Request
	input  wire logic [2:0] new_osc_select,
	// Status
	output logic [2:0]      current_osc_select,
	output logic            switch_done
);

	typedef enum logic [0:0] {SW_IDLE, SW_SETTLE} sw_state_t;

	sw_state_t  state_q, state_d;
	logic [3:0] count_q, count_d;
	logic [2:0] cur_q, cur_d;
	logic [2:0] target_q, target_d;
	logic       done_q, done_d;

	// A new request seen mid settle restarts the wait, so the reported source
	// never shows a value the clock tree did not settle on.
	always_comb begin
		state_d  = state_q;
		count_d  = count_q;
		cur_d    = cur_q;
		target_d = target_q;
		done_d   = 1'b0;
		unique case (state_q)
			SW_IDLE: begin
				if (new_osc_select != cur_q) begin
					state_d  = SW_SETTLE;
					target_d = new_osc_select;
					count_d  = SWITCH_COUNT;
				end
			end
			SW_SETTLE: begin
				if (new_osc_select != target_q) begin
					target_d = new_osc_select;
					count_d  = SWITCH_COUNT;
				end else if (count_q == 4'h1) begin
					cur_d   = target_q; // RULE16
					done_d  = 1'b1;
					state_d = SW_IDLE;
				end else begin
					count_d = count_q - 4'h1;
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q  <= SW_IDLE;
			count_q  <= 4'h0;
			cur_q    <= SRC_FAST_RC;
			target_q <= SRC_FAST_RC;
			done_q   <= 1'b0;
		end else begin
			state_q  <= state_d;
			count_q  <= count_d;
			cur_q    <= cur_d;
			target_q <= target_d;
			done_q   <= done_d;
		end
	end

	assign current_osc_select = cur_q;
	assign switch_done        = done_q;

endmodule

// >>> logic/osc_ctrl_pkg.sv
// Register map, field layout and timing constants for the oscillator select control.
package osc_ctrl_pkg;

	// Register byte addresses on the register bus.
	localparam logic [7:0] OSC_CONTROL_ADDR = 8'h00;
	localparam logic [7:0] UNLOCK_KEY_ADDR  = 8'h04;
	localparam logic [7:0] IRQ_STATUS_ADDR  = 8'h08;
	localparam logic [7:0] IRQ_MASK_ADDR    = 8'h0c;

	// Field positions inside oscillator_control.
	localparam int PLL_MULT_LSB    = 16;
	localparam int CUR_OSC_LSB     = 12;
	localparam int NEW_OSC_LSB     = 8;
	localparam int SEL_LOCK_BIT    = 7;
	localparam int USB_LOCKED_BIT  = 6;
	localparam int SYS_LOCKED_BIT  = 5;
	localparam int SLEEP_WAIT_BIT  = 4;
	localparam int CLK_FAIL_BIT    = 3;

	// Interrupt status bit positions.
	localparam int IRQ_SWITCH_DONE = 0;
	localparam int IRQ_CLK_FAIL    = 1;
	localparam int IRQ_KEY_FAULT   = 2;
	localparam int IRQ_BITS        = 3;

	// Reset values.
	localparam logic [2:0] PLL_MULT_RESET = 3'h0;
	localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

	// Unlock keys, arbitrary values, written in this order to the key register.
	localparam logic [31:0] UNLOCK_KEY1 = 32'h5a5a_1234;
	localparam logic [31:0] UNLOCK_KEY2 = 32'ha5a5_4321;

	// Settle time of a clock switch, in ns, and its cycle count at 100 ns per clock.
	localparam int CLK_PERIOD_NS   = 100;
	localparam int SWITCH_TIME_NS  = 800;
	localparam int SWITCH_CYCLES   = (SWITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] SWITCH_COUNT = 4'(SWITCH_CYCLES);

	// Clock source encodings, shared by the current and new source fields.
	localparam logic [2:0] SRC_FAST_RC       = 3'h0;
	localparam logic [2:0] SRC_FAST_RC_PLL   = 3'h1;
	localparam logic [2:0] SRC_PRIMARY       = 3'h2;
	localparam logic [2:0] SRC_PRIMARY_PLL   = 3'h3;
	localparam logic [2:0] SRC_SECONDARY     = 3'h4;
	localparam logic [2:0] SRC_LOW_POWER_RC  = 3'h5;
	localparam logic [2:0] SRC_FAST_RC_DIV16 = 3'h6;
	localparam logic [2:0] SRC_FAST_RC_DIVN  = 3'h7;

endpackage

// >>> logic/oscillator_select_control.sv
// Oscillator control register with unlock-guarded AXI4-Lite access and event interrupt.

////////////////////////////////////////////////////////////////////////////////

// Functional notes
// RULE1: The three-bit PLL field picks factors 15 to 19 for codes 0 to 4, then 20, 21 and 24.
// RULE2: The active clock source reads back in bits 14 to 12.
// RULE3: Sources 0-7 are fast RC, RC+PLL, primary, primary+PLL, secondary, LP RC, RC/16, RC/N.
// RULE4: The requested source is a writable field in bits 10 to 8 with the same coding.
// RULE5: Every reset loads the requested source from the configuration word's initial selection.
// RULE6: With switch/monitor config 1x a set lock bit 7 freezes clock and PLL selections.
// RULE7: With switch/monitor config 0x the selections are never locked.
// RULE8: Bit 6 reads one when the USB PLL is locked or its start-up timer expired.
// RULE9: Bit 5 reads one when the system PLL is locked or its start-up timer expired.
// RULE10: Bit 4 chooses sleep (1) or idle (0) for a wait instruction.
// RULE11: Bit 3 is set when the fail-safe monitor sees a clock failure.
// RULE12: A write to the control register is taken only after an unlock sequence, once per write.
// RULE13: The control register has no clear, set or invert alias addresses.
// RULE14: Bits 15 and 11 are unimplemented and read as zero.
// RULE15: Key values and their order are parameters; writes without the full sequence are ignored.
// RULE16: When a clock switch completes the current source equals the requested one.
module oscillator_select_control
	import osc_ctrl_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Configuration word fields
	input  wire logic [2:0]  initial_osc_config,
	input  wire logic [1:0]  switch_monitor_config,
	// Clock tree status
	input  wire logic        usb_pll_locked_in,
	input  wire logic        usb_pll_timer_done,
	input  wire logic        sys_pll_locked_in,
	input  wire logic        sys_pll_timer_done,
	input  wire logic        fail_safe_monitor_fail,
	// Clock tree and power control
	output logic [2:0]       pll_multiplier,
	output logic [4:0]       pll_factor,
	output logic [2:0]       new_osc_select,
	output logic [2:0]       current_osc_select,
	input  wire logic        wait_exec,
	output logic             enter_sleep,
	output logic             enter_idle,
	// Interrupt
	output logic             irq
);

	////////////////////////////////////////////////////////////////////////////////
	// Register state.

	logic [2:0]          pll_q, pll_d;
	logic [2:0]          req_q, req_d;
	logic                lock_q, lock_d;
	logic                slp_q, slp_d;
	logic                fail_q, fail_d;
	logic [1:0]          key_q, key_d;
	logic [IRQ_BITS-1:0] stat_q, stat_d;
	logic [IRQ_BITS-1:0] mask_q, mask_d;
	logic                req_load_q;

	// Write channel state.
	logic        aw_held_q, aw_held_d;
	logic        w_held_q, w_held_d;
	logic [7:0]  awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0]  wstrb_q, wstrb_d;
	logic        bvalid_q, bvalid_d;
	logic [1:0]  bresp_q, bresp_d;

	// Read channel state.
	logic        rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0]  rresp_q, rresp_d;

	logic        switch_done;
	logic [2:0]  cur_osc;
	logic        frozen;
	logic        wr_fire;
	logic [31:0] osc_word;

	clock_switcher u_switch (
		.aclk               (aclk),
		.aresetn            (aresetn),
		.new_osc_select     (req_q),
		.current_osc_select (cur_osc),
		.switch_done        (switch_done)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Read-back view and derived status.

	assign frozen = switch_monitor_config[1] & lock_q; // RULE6 RULE7

	always_comb begin
		osc_word = 32'h0; // RULE14
		osc_word[PLL_MULT_LSB +: 3] = pll_q;
		osc_word[CUR_OSC_LSB +: 3]  = cur_osc; // RULE2 RULE3
		osc_word[NEW_OSC_LSB +: 3]  = req_q; // RULE4
		osc_word[SEL_LOCK_BIT]      = lock_q;
		osc_word[USB_LOCKED_BIT]    = usb_pll_locked_in | usb_pll_timer_done; // RULE8
		osc_word[SYS_LOCKED_BIT]    = sys_pll_locked_in | sys_pll_timer_done; // RULE9
		osc_word[SLEEP_WAIT_BIT]    = slp_q;
		osc_word[CLK_FAIL_BIT]      = fail_q;
	end

	always_comb begin
		unique case (pll_q) // RULE1
			3'h5:    pll_factor = 5'h14;
			3'h6:    pll_factor = 5'h15;
			3'h7:    pll_factor = 5'h18;
			default: pll_factor = 5'h0f + {2'h0, pll_q};
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Write path: address and data are taken in either order, then one response.

	assign s_axi_awready = !aw_held_q && !bvalid_q;
	assign s_axi_wready  = !w_held_q && !bvalid_q;
	// Built from the held flags and this cycle's handshakes, not from next-state
	// values, so the strobe cannot feed back through the flags that it clears.
	assign wr_fire       = (aw_held_q || (s_axi_awvalid && s_axi_awready))
		&& (w_held_q || (s_axi_wvalid && s_axi_wready)) && !bvalid_q;

	always_comb begin
		aw_held_d = aw_held_q;
		w_held_d  = w_held_q;
		awaddr_d  = awaddr_q;
		wdata_d   = wdata_q;
		wstrb_d   = wstrb_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		pll_d     = pll_q;
		req_d     = req_q;
		lock_d    = lock_q;
		slp_d     = slp_q;
		key_d     = key_q;
		mask_d    = mask_q;
		stat_d    = stat_q;
		fail_d    = fail_q | fail_safe_monitor_fail; // RULE11
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held_d = 1'b1;
			awaddr_d  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held_d = 1'b1;
			wdata_d  = s_axi_wdata;
			wstrb_d  = s_axi_wstrb;
		end
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (wr_fire) begin
			aw_held_d = 1'b0;
			w_held_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = 2'b00;
			// Only the plain word address decodes; alias offsets fall to SLVERR.
			unique case (awaddr_d) // RULE13
				UNLOCK_KEY_ADDR: begin
					if (key_q == 2'h0 && wdata_d == UNLOCK_KEY1) begin // RULE15
						key_d = 2'h1;
					end else if (key_q == 2'h1 && wdata_d == UNLOCK_KEY2) begin
						key_d = 2'h2;
					end else begin
						key_d = 2'h0;
					end
				end
				OSC_CONTROL_ADDR: begin
					key_d = 2'h0; // RULE12
					if (key_q == 2'h2) begin // RULE12 RULE15
						if (!frozen && wstrb_d[2]) begin // RULE6 RULE7
							pll_d = wdata_d[PLL_MULT_LSB +: 3];
						end
						if (!frozen && wstrb_d[1]) begin
							req_d = wdata_d[NEW_OSC_LSB +: 3];
						end
						if (wstrb_d[0]) begin
							lock_d = wdata_d[SEL_LOCK_BIT];
							slp_d  = wdata_d[SLEEP_WAIT_BIT];
							// Software may only clear the fail flag; a new failure wins.
							fail_d = (fail_q & wdata_d[CLK_FAIL_BIT]) | fail_safe_monitor_fail;
						end
					end else begin
						stat_d[IRQ_KEY_FAULT] = 1'b1;
						bresp_d = 2'b10;
					end
				end
				IRQ_STATUS_ADDR: begin
					if (wstrb_d[0]) begin
						stat_d = stat_q & ~wdata_d[IRQ_BITS-1:0];
					end
				end
				IRQ_MASK_ADDR: begin
					if (wstrb_d[0]) begin
						mask_d = wdata_d[IRQ_BITS-1:0];
					end
				end
				default: bresp_d = 2'b10;
			endcase
		end
		// Hardware events are applied last so a set in the clear cycle wins.
		if (switch_done) begin
			stat_d[IRQ_SWITCH_DONE] = 1'b1;
		end
		if (fail_safe_monitor_fail && !fail_q) begin
			stat_d[IRQ_CLK_FAIL] = 1'b1;
		end
		if (!req_load_q) begin
			req_d = initial_osc_config; // RULE5
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path: one cycle from address to data.

	assign s_axi_arready = !rvalid_q;

	always_comb begin
		rvalid_d = rvalid_q;
		rdata_d  = rdata_q;
		rresp_d  = rresp_q;
		if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rresp_d  = 2'b00;
			rdata_d  = 32'h0;
			unique case (s_axi_araddr)
				OSC_CONTROL_ADDR: rdata_d = osc_word;
				UNLOCK_KEY_ADDR:  rdata_d = {30'h0, key_q};
				IRQ_STATUS_ADDR:  rdata_d = {29'h0, stat_q};
				IRQ_MASK_ADDR:    rdata_d = {29'h0, mask_q};
				default:          rresp_d = 2'b10;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers.

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pll_q       <= PLL_MULT_RESET;
			req_q       <= SRC_FAST_RC;
			req_load_q  <= 1'b0;
			lock_q      <= 1'b0;
			slp_q       <= 1'b0;
			fail_q      <= 1'b0;
			key_q       <= 2'h0;
			stat_q      <= '0;
			mask_q      <= IRQ_MASK_RESET;
			aw_held_q   <= 1'b0;
			w_held_q    <= 1'b0;
			awaddr_q    <= 8'h0;
			wdata_q     <= 32'h0;
			wstrb_q     <= 4'h0;
			bvalid_q    <= 1'b0;
			bresp_q     <= 2'b00;
			rvalid_q    <= 1'b0;
			rdata_q     <= 32'h0;
			rresp_q     <= 2'b00;
		end else begin
			pll_q       <= pll_d;
			req_q       <= req_d;
			req_load_q  <= 1'b1;
			lock_q      <= lock_d;
			slp_q       <= slp_d;
			fail_q      <= fail_d;
			key_q       <= key_d;
			stat_q      <= stat_d;
			mask_q      <= mask_d;
			aw_held_q   <= aw_held_d;
			w_held_q    <= w_held_d;
			awaddr_q    <= awaddr_d;
			wdata_q     <= wdata_d;
			wstrb_q     <= wstrb_d;
			bvalid_q    <= bvalid_d;
			bresp_q     <= bresp_d;
			rvalid_q    <= rvalid_d;
			rdata_q     <= rdata_d;
			rresp_q     <= rresp_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs.

	assign s_axi_bvalid       = bvalid_q;
	assign s_axi_bresp        = bresp_q;
	assign s_axi_rvalid       = rvalid_q;
	assign s_axi_rdata        = rdata_q;
	assign s_axi_rresp        = rresp_q;
	assign pll_multiplier     = pll_q;
	assign new_osc_select     = req_q;
	assign current_osc_select = cur_osc;
	assign enter_sleep        = wait_exec & slp_q; // RULE10
	assign enter_idle         = wait_exec & ~slp_q; // RULE10
	assign irq                = |(stat_q & mask_q);

endmodule

// >>> verification/osc_ctrl_checker_properties.sv
// Port-level assertions for the oscillator select control.
module osc_ctrl_checker
	import osc_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	// Clock tree
	input wire logic [2:0]  initial_osc_config,
	input wire logic [2:0]  pll_multiplier,
	input wire logic [4:0]  pll_factor,
	input wire logic [2:0]  new_osc_select,
	input wire logic [2:0]  current_osc_select,
	input wire logic        wait_exec,
	input wire logic        enter_sleep,
	input wire logic        enter_idle
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	function automatic logic [4:0] fx(input logic [2:0] m);
		return (m < 3'h5) ? 5'h0f + {2'h0, m} : (m == 3'h5) ? 5'h14 : (m == 3'h6) ? 5'h15 : 5'h18;
	endfunction

	////////////////////////////////////////
	sequence s_rd_ctl;
		s_axi_arvalid && s_axi_arready && s_axi_araddr == OSC_CONTROL_ADDR;
	endsequence
	sequence s_moved;
		$changed(current_osc_select);
	endsequence

	property p_factor;
		pll_factor == fx(pll_multiplier);
	endproperty
	a_factor: assert property (p_factor) else $error("pll factor wrong");
	property p_mode;
		(enter_sleep || enter_idle) == wait_exec && !(enter_sleep && enter_idle);
	endproperty
	a_mode: assert property (p_mode) else $error("wait mode wrong");
	property p_switch;
		s_moved |-> current_osc_select == $past(new_osc_select);
	endproperty
	a_switch: assert property (p_switch) else $error("source not the request");
	// A source already matching the request must not wander.
	property p_still;
		new_osc_select == current_osc_select |=> $stable(current_osc_select);
	endproperty
	a_still: assert property (p_still) else $error("source moved");
	property p_reset_load;
		$rose(aresetn) |=> new_osc_select == $past(initial_osc_config);
	endproperty
	a_reset_load: assert property (p_reset_load) else $error("reset load");
	property p_rdfields;
		s_rd_ctl |=> (s_axi_rdata & 32'hfff8_8800) == 32'h0
			&& s_axi_rdata[14:12] == $past(current_osc_select)
			&& s_axi_rdata[10:8] == $past(new_osc_select)
			&& s_axi_rdata[18:16] == $past(pll_multiplier);
	endproperty
	a_rdfields: assert property (p_rdfields) else $error("read fields");
	property p_unmapped;
		s_axi_arvalid && s_axi_arready && s_axi_araddr > IRQ_MASK_ADDR
			|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("alias answered");
	property p_rd_ans;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
	property p_wr_ans;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
	endproperty
	a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
endmodule

bind oscillator_select_control osc_ctrl_checker u_chk (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .initial_osc_config, .pll_multiplier, .pll_factor,
	.new_osc_select, .current_osc_select, .wait_exec, .enter_sleep, .enter_idle
);

// >>> verification/tb.sv
// Self-checking bench for the oscillator select control.
module tb
	import osc_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic [2:0]  initial_osc_config = 3'h0;
	logic [1:0]  switch_monitor_config = 2'h0;
	logic        usb_pll_locked_in = 1'b0, usb_pll_timer_done = 1'b0;
	logic        sys_pll_locked_in = 1'b0, sys_pll_timer_done = 1'b0;
	logic        fail_safe_monitor_fail = 1'b0, wait_exec = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] s_axi_rdata, dat;
	logic [2:0]  pll_multiplier, new_osc_select, current_osc_select;
	logic [4:0]  pll_factor;
	logic        enter_sleep, enter_idle;
	int          n_fail = 0, checked = 0;

	// Response channels are always ready, so answers are never stalled here.
	oscillator_select_control DUT (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .initial_osc_config,
		.switch_monitor_config, .usb_pll_locked_in, .usb_pll_timer_done, .sys_pll_locked_in,
		.sys_pll_timer_done, .fail_safe_monitor_fail, .pll_multiplier, .pll_factor,
		.new_osc_select, .current_osc_select, .wait_exec, .enter_sleep, .enter_idle, .irq
	);

	initial begin
		forever #50 aclk = ~aclk;
	end

	////////////////////////////////////////
	task automatic finish_test;
		if (n_fail == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic tmo(input int n);
		if (n >= 60) begin
			n_fail++;
			$display("BAD %0t no answer", $time);
			finish_test();
		end
	endtask
	// Handshakes are judged at the falling edge, where the values that the next
	// rising edge samples have settled; reading them at the rising edge races the design.
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int   n;
		logic aw_t, w_t, b_t;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (n = 0; n < 60; n++) begin
			@(negedge aclk);
			aw_t = s_axi_awvalid && s_axi_awready;
			w_t = s_axi_wvalid && s_axi_wready;
			b_t = s_axi_bvalid;
			rsp = s_axi_bresp;
			@(posedge aclk);
			if (aw_t) s_axi_awvalid <= 1'b0;
			if (w_t) s_axi_wvalid <= 1'b0;
			if (b_t) break;
		end
		tmo(n);
	endtask
	task automatic rd(input logic [7:0] a);
		int   n;
		logic ar_t, r_t;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (n = 0; n < 60; n++) begin
			@(negedge aclk);
			ar_t = s_axi_arvalid && s_axi_arready;
			r_t = s_axi_rvalid;
			dat = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge aclk);
			if (ar_t) s_axi_arvalid <= 1'b0;
			if (r_t) break;
		end
		tmo(n);
	endtask
	task automatic uwr(input logic [31:0] v);
		wr(UNLOCK_KEY_ADDR, UNLOCK_KEY1);
		wr(UNLOCK_KEY_ADDR, UNLOCK_KEY2);
		wr(OSC_CONTROL_ADDR, v);
	endtask
	// Control word with the clock-fail bit at one, which leaves the flag as it is.
	function automatic logic [31:0] cw(input logic [2:0] p, s, input logic lk, sl);
		return {13'h0, p, 5'h0, s, lk, 2'h0, sl, 1'b1, 3'h0};
	endfunction
	task automatic wait_cur(input logic [2:0] v);
		int n;
		for (n = 0; n < 60; n++) begin
			@(negedge aclk);
			if (current_osc_select === v) break;
			@(posedge aclk);
		end
		@(posedge aclk);
		tmo(n);
	endtask

	////////////////////////////////////////
	task automatic t_init(input logic [2:0] c);
		initial_osc_config <= c;
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(OSC_CONTROL_ADDR);
		chk(dat & 32'hffff_0f00, {21'h0, c, 8'h00});
		wait_cur(c);
		rd(OSC_CONTROL_ADDR);
		chk(dat & 32'hffff_ff00, {17'h0, c, 1'b0, c, 8'h00});
		rd(IRQ_STATUS_ADDR);
		chk(dat, 32'h1);
	endtask
	task automatic t_guard;
		wr(OSC_CONTROL_ADDR, cw(3'h3, 3'h2, 1'b0, 1'b0));
		chk({30'h0, rsp}, 32'h2);
		wr(UNLOCK_KEY_ADDR, UNLOCK_KEY2);
		wr(UNLOCK_KEY_ADDR, UNLOCK_KEY1);
		wr(OSC_CONTROL_ADDR, cw(3'h3, 3'h2, 1'b0, 1'b0));
		chk({30'h0, rsp}, 32'h2);
		rd(OSC_CONTROL_ADDR);
		chk(dat & 32'h7_0000, 32'h0);
		uwr(cw(3'h3, 3'h2, 1'b0, 1'b0));
		chk({30'h0, rsp}, 32'h0);
		wr(OSC_CONTROL_ADDR, cw(3'h5, 3'h2, 1'b0, 1'b0));
		chk({30'h0, rsp}, 32'h2);
		rd(OSC_CONTROL_ADDR);
		chk(dat & 32'h7_0000, 32'h3_0000);
		rd(IRQ_STATUS_ADDR);
		chk(dat & 32'h4, 32'h4);
		wr(IRQ_STATUS_ADDR, 32'h7);
		rd(IRQ_STATUS_ADDR);
		chk(dat, 32'h0);
	endtask
	task automatic t_pll;
		logic [31:0] e;
		for (int i = 0; i < 8; i++) begin
			e = (i < 5) ? 32'h0f + i : (i == 5) ? 32'h14 : (i == 6) ? 32'h15 : 32'h18;
			uwr(cw(3'(i), 3'h2, 1'b0, 1'b0));
			chk({27'h0, pll_factor}, e);
			chk({29'h0, pll_multiplier}, 32'(i));
		end
	endtask
	task automatic t_src;
		wr(IRQ_MASK_ADDR, 32'h1);
		for (int i = 0; i < 8; i++) begin
			uwr(cw(3'h0, 3'(i), 1'b0, 1'b0));
			chk({29'h0, new_osc_select}, 32'(i));
			wait_cur(3'(i));
			rd(OSC_CONTROL_ADDR);
			chk(dat & 32'h7700, {17'h0, 3'(i), 1'b0, 3'(i), 8'h00});
		end
		chk({31'h0, irq}, 32'h1);
		wr(IRQ_STATUS_ADDR, 32'h1);
		@(posedge aclk);
		chk({31'h0, irq}, 32'h0);
		wr(IRQ_MASK_ADDR, 32'h0);
	endtask
	task automatic t_lock;
		switch_monitor_config <= 2'h2;
		uwr(cw(3'h0, 3'h7, 1'b1, 1'b0));
		uwr(cw(3'h5, 3'h3, 1'b1, 1'b0));
		rd(OSC_CONTROL_ADDR);
		chk(dat & 32'h7_0780, 32'h0_0780);
		switch_monitor_config <= 2'h1;
		uwr(cw(3'h5, 3'h3, 1'b1, 1'b0));
		rd(OSC_CONTROL_ADDR);
		chk(dat & 32'h7_0780, 32'h5_0380);
		switch_monitor_config <= 2'h3;
		uwr(cw(3'h5, 3'h3, 1'b0, 1'b0));
		uwr(cw(3'h6, 3'h3, 1'b0, 1'b0));
		rd(OSC_CONTROL_ADDR);
		chk(dat & 32'h7_0780, 32'h6_0300);
		wait_cur(3'h3);
	endtask
	task automatic t_stat;
		for (int i = 0; i < 16; i++) begin
			{usb_pll_locked_in, usb_pll_timer_done, sys_pll_locked_in, sys_pll_timer_done} <= 4'(i);
			rd(OSC_CONTROL_ADDR);
			chk(dat & 32'h60, {25'h0, i[3] | i[2], i[1] | i[0], 5'h0});
		end
	endtask
	task automatic t_sleep;
		wait_exec <= 1'b1;
		uwr(cw(3'h6, 3'h3, 1'b0, 1'b1));
		@(posedge aclk);
		chk({30'h0, enter_sleep, enter_idle}, 32'h2);
		uwr(cw(3'h6, 3'h3, 1'b0, 1'b0));
		@(posedge aclk);
		chk({30'h0, enter_sleep, enter_idle}, 32'h1);
		wait_exec <= 1'b0;
		@(posedge aclk);
		chk({30'h0, enter_sleep, enter_idle}, 32'h0);
	endtask
	task automatic t_fail;
		rd(OSC_CONTROL_ADDR);
		chk(dat & 32'h8, 32'h0);
		fail_safe_monitor_fail <= 1'b1;
		@(posedge aclk);
		fail_safe_monitor_fail <= 1'b0;
		repeat (2) @(posedge aclk);
		chk({31'h0, irq}, 32'h0);
		rd(OSC_CONTROL_ADDR);
		chk(dat & 32'h8, 32'h8);
		wr(IRQ_MASK_ADDR, 32'h2);
		@(posedge aclk);
		chk({31'h0, irq}, 32'h1);
		uwr(cw(3'h6, 3'h3, 1'b0, 1'b0) ^ 32'h8);
		rd(OSC_CONTROL_ADDR);
		chk(dat & 32'h8, 32'h0);
		wr(IRQ_STATUS_ADDR, 32'h2);
		@(posedge aclk);
		chk({31'h0, irq}, 32'h0);
	endtask
	task automatic t_alias;
		for (int i = 4; i < 8; i++) begin
			rd(8'(4 * i));
			chk(dat, 32'h0);
			chk({30'h0, rsp}, 32'h2);
		end
	endtask

	initial begin
		t_init(SRC_PRIMARY);
		t_guard();
		t_pll();
		t_src();
		t_lock();
		t_stat();
		t_sleep();
		t_fail();
		t_alias();
		t_init(SRC_SECONDARY);
		finish_test();
	end
endmodule
